// ==== rtl/spf_port.sv ====
// spf_port: one switch port slice, receive and transmit MAC with input and output control
// assumes link pins are asynchronous to hclk and toggle far slower than hclk
//
// Our own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module spf_port
  import spf_pkg::*;
#(
  parameter logic [15:0] PORT_ID = 16'h0000
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [5:0] strap_led_pins,
  input wire logic rx_clk,
  input wire logic rx_dv,
  input wire logic [3:0] rxd,
  input wire logic rx_er,
  input wire logic crs,
  output logic tx_en,
  output logic [3:0] txd,
  output spf_mac_t fwd_da,
  output spf_mac_t learn_sa,
  output logic qw_valid,
  output logic [63:0] qw_data,
  output logic enq_valid,
  output logic [18:0] enq_buf,
  output logic rx_abort,
  input wire logic pub_buf_valid,
  input wire logic [18:0] pub_buf,
  output logic pub_take,
  input wire logic deq_valid,
  input wire logic [18:0] deq_buf,
  output logic deq_ready,
  input wire logic tx_word_valid,
  input wire logic [15:0] tx_word,
  input wire logic tx_word_last,
  output logic tx_word_ready,
  output logic free_valid,
  output logic [18:0] free_buf,
  output spf_phy_cmd_t phy_cmd,
  output logic phy_req,
  input wire logic phy_ack,
  input wire logic [15:0] phy_rdata
);
  typedef enum logic [1:0] {RX_IDLE, RX_PRE, RX_DATA, RX_DONE} spf_rx_st_t;
  typedef enum logic [1:0] {TX_IDLE, TX_DEFER, TX_PRE, TX_DATA} spf_tx_st_t;
  typedef struct packed {
    logic a_wr, a_rd, hreadyout, hresp;
    logic [7:0] a_addr;
    logic [31:0] hrdata;
    logic [5:0] ctrl;
    logic phy_req;
    spf_phy_cmd_t phy_cmd;
    logic [15:0] phy_rd;
    logic [5:0] st1, st2;
    logic [1:0] st_cnt;
    logic st_done;
    spf_strap_t strap;
    logic [7:0] l1, l2;
    logic clk_d;
    logic [7:0] per;
    logic spd100;
    spf_rx_st_t rx_st;
    logic [15:0] rx_w;
    logic [4:0] rx_b;
    logic [2:0] rx_wc;
    logic [1:0] rx_qn;
    logic [63:0] rx_qw;
    logic [31:0] crc;
    logic er_seen, good, enq_done;
    logic [7:0] qwc;
    spf_mac_t fwd, learn;
    logic qw_valid, enq_valid, abort;
    logic [63:0] qw_data;
    logic [18:0] enq_buf;
    logic [7:0] pmap;
    logic [18:0] cur;
    logic cur_ok, pub_take;
    spf_tx_st_t tx_st;
    logic [18:0] tx_buf, free_buf;
    logic [15:0] tx_sh;
    logic [4:0] tx_b;
    logic [5:0] tx_c;
    logic tx_last, tx_en, wrdy, free_valid, deq_ready;
    logic [3:0] txd;
    logic [15:0] good_cnt;
  } spf_state_t;

  spf_state_t s, n;

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [3:0] d,
                                           input logic rm);
    logic [31:0] r;
    logic fb;
    r = c;
    for (int i = 0; i < 4; i++) begin
      if (!rm || i < 2) begin
        fb = r[0] ^ d[i];
        r = {1'b0, r[31:1]} ^ (fb ? CRC_POLY : 32'h0);
      end
    end
    return r;
  endfunction : crc_step

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic tick, dv, er, cs, srst, rm;
    logic [3:0] d;
    logic [4:0] nb;
    logic [5:0] ifg;
    logic [2:0] pick;
    spf_strap_pins_t sp;
    spf_phy_reg_t pw;
    tick = 1'b0;
    dv = 1'b0;
    er = 1'b0;
    cs = 1'b0;
    srst = 1'b0;
    d = 4'h0;
    pick = 3'h0;
    n = s;
    n.fwd.valid = 1'b0;
    n.learn.valid = 1'b0;
    n.qw_valid = 1'b0;
    n.enq_valid = 1'b0;
    n.abort = 1'b0;
    n.pub_take = 1'b0;
    n.free_valid = 1'b0;
    n.hreadyout = 1'b1;
    rm = s.strap.rmii;
    nb = rm ? 5'h02 : 5'h04;
    ifg = rm ? IFG_T_RMII : IFG_T_MII;
    pw = spf_phy_reg_t'(hwdata);
    sp = spf_strap_pins_t'(s.st2);
    // bus slave: zero wait states, unmapped reads return zero, writes dropped
    n.a_wr = hsel && htrans[1] && hready && hwrite;
    n.a_rd = hsel && htrans[1] && hready && !hwrite;
    n.a_addr = haddr[7:0];
    if (n.a_rd) begin
      case (haddr[7:0])
        OFS_CTRL: n.hrdata = {26'h0, s.ctrl};
        OFS_STATUS: n.hrdata = {9'h0, s.spd100, s.strap};
        OFS_BUF: n.hrdata = {4'h0, s.cur_ok, s.cur, s.pmap};
        OFS_RXGOOD: n.hrdata = {16'h0, s.good_cnt};
        OFS_PHY: n.hrdata = {s.phy_rd, s.phy_cmd.wr, s.phy_cmd.phy, s.phy_cmd.regno,
                             s.phy_req, 4'h0};
        default: n.hrdata = 32'h0;
      endcase
    end
    if (s.a_wr) begin
      case (s.a_addr)
        OFS_CTRL: begin
          n.ctrl = hwdata[5:0] & ~(6'h01 << CB_SRST);
          srst = hwdata[CB_SRST];
        end
        OFS_PHY: begin
          if (!s.phy_req) begin
            n.phy_req = 1'b1;
            n.phy_cmd = '{wr: pw.wr, phy: pw.phy, regno: pw.regno, wdata: pw.data};
          end
        end
        default: ;
      endcase
    end
    if (s.phy_req && phy_ack) begin
      n.phy_req = 1'b0;
      n.phy_rd = phy_rdata;
    end
    // straps are read once, a few cycles after reset release
    n.st1 = strap_led_pins;
    n.st2 = s.st1;
    if (!s.st_done) begin
      n.st_cnt = s.st_cnt + 2'h1;
      if (s.st_cnt == STRAP_WAIT) begin
        n.st_done = 1'b1;
        case (sp.hclk)
          HC_8: n.strap.host_mhz = 8'h08;
          HC_16: n.strap.host_mhz = 8'h10;
          HC_25: n.strap.host_mhz = 8'h19;
          HC_4: n.strap.host_mhz = 8'h04;
          HC_33: n.strap.host_mhz = 8'h21;
          default: n.strap.host_mhz = 8'h00;
        endcase
        n.strap.rmii = sp.phy;
        case (sp.sram)
          SR_64K: n.strap.sram_kw = 8'h40;
          SR_128K: n.strap.sram_kw = 8'h80;
          SR_32K: n.strap.sram_kw = 8'h20;
          default: n.strap.sram_kw = 8'h00;
        endcase
        n.strap.ports = sp.phy ? PORTS_RMII : PORTS_MII;
      end
    end
    // link pins: {clk, dv, er, crs, data}; sample on falling clock, mid-bit
    n.l1 = {rx_clk, rx_dv, rx_er, crs, rxd};
    n.l2 = s.l1;
    n.clk_d = s.l2[7];
    tick = s.clk_d && !s.l2[7] && s.st_done;
    {dv, er, cs, d} = s.l2[6:0];
    // speed sense by link period, or manual
    n.per = (s.per == 8'hff) ? s.per : s.per + 8'h01;
    if (tick) begin
      n.per = 8'h00;
      n.spd100 = s.ctrl[CB_AUTO] ? (s.per < SPD_THR) : s.ctrl[CB_S100];
    end
    ////////////////////////////////////////////////////////////////////////////
    // one symbol per tick, never stalled
    if (tick) begin
      case (s.rx_st)
        RX_IDLE: begin
          if (dv && s.ctrl[CB_EN] && s.cur_ok) begin
            n.rx_st = RX_PRE;
            n.crc = CRC_INIT;
            n.er_seen = 1'b0;
            n.enq_done = 1'b0;
            n.rx_wc = 3'h0;
            n.rx_qn = 2'h0;
            n.rx_b = 5'h00;
            n.qwc = 8'h00;
          end
        end
        RX_PRE: begin
          if (!dv) n.rx_st = RX_IDLE;
          else if (rm ? (d[1:0] == 2'b11) : (d == 4'hd)) n.rx_st = RX_DATA;
        end
        RX_DATA: begin
          if (dv) begin
            n.crc = crc_step(s.crc, d, rm);
            n.rx_w = rm ? {d[1:0], s.rx_w[15:2]} : {d, s.rx_w[15:4]};
            n.rx_b = s.rx_b + nb;
            if (n.rx_b == WORD_BITS) begin
              n.rx_b = 5'h00;
              if (s.rx_wc < DA_WORDS) n.fwd.mac = {n.rx_w, s.fwd.mac[47:16]};
              else if (s.rx_wc < HDR_WORDS) n.learn.mac = {n.rx_w, s.learn.mac[47:16]};
              n.fwd.valid = (s.rx_wc == DA_WORDS - 3'h1);
              if (s.rx_wc != HDR_WORDS) n.rx_wc = s.rx_wc + 3'h1;
              n.rx_qw = {n.rx_w, s.rx_qw[63:16]};
              n.rx_qn = s.rx_qn + 2'h1;
              if (s.rx_qn == 2'h3) begin
                n.qw_valid = 1'b1;
                n.qw_data = n.rx_qw;
                n.qwc = s.qwc + 8'h01;
              end
            end
          end else begin
            if (s.rx_qn != 2'h0) begin
              n.qw_valid = 1'b1;
              n.qw_data = s.rx_qw >> 7'({3'h4 - {1'b0, s.rx_qn}, 4'h0});
            end
            n.good = !s.er_seen && (s.crc == CRC_RES) && (s.rx_b == 5'h00);
            n.rx_st = RX_DONE;
          end
        end
        default: ;
      endcase
    end
    // frame that fills one whole buffer or more is abandoned
    if (s.rx_st == RX_DATA && !s.er_seen && (er || s.qwc >= BUF_QWORDS)) begin
      n.er_seen = 1'b1;
      n.abort = 1'b1;
    end
    if (s.rx_st == RX_DATA && s.ctrl[CB_CUT] && !s.enq_done && !n.er_seen
        && s.qwc >= CT_THRESH_QW) begin
      n.enq_valid = 1'b1;
      n.enq_buf = s.cur;
      n.enq_done = 1'b1;
      n.cur_ok = 1'b0;
    end
    if (s.rx_st == RX_DONE) begin
      n.rx_st = RX_IDLE;
      if (s.good) begin
        n.learn.valid = 1'b1;
        n.good_cnt = s.good_cnt + 16'h0001;
        if (!s.enq_done) begin
          n.enq_valid = 1'b1;
          n.enq_buf = s.cur;
          n.cur_ok = 1'b0;
        end
      end else if (!s.er_seen) begin
        n.abort = 1'b1;
      end
    end
    ////////////////////////////////////////////////////////////////////////////
    case (s.tx_st)
      TX_IDLE: begin
        // dequeue once the output FIFO holds the packet
        if (deq_valid && s.ctrl[CB_EN] && s.st_done) begin
          n.tx_buf = deq_buf;
          n.tx_st = TX_DEFER;
          n.tx_c = 6'h00;
          n.tx_last = 1'b0;
          n.tx_b = 5'h00;
        end
      end
      TX_DEFER: begin
        // deferral: carrier holds off half duplex, gap always kept
        if (tick) begin
          if (cs && !s.ctrl[CB_FDX]) n.tx_c = 6'h00;
          else n.tx_c = s.tx_c + 6'h01;
          if (n.tx_c >= ifg) begin
            n.tx_st = TX_PRE;
            n.tx_c = 6'h00;
          end
        end
      end
      default: begin
        if (tick && s.tx_b != 5'h00) begin
          n.tx_en = 1'b1;
          n.txd = rm ? {2'b00, s.tx_sh[1:0]} : s.tx_sh[3:0];
          n.tx_sh = s.tx_sh >> nb;
          n.tx_b = s.tx_b - nb;
        end else if (s.tx_b == 5'h00) begin
          if (s.tx_st == TX_PRE) begin
            if (s.tx_c < PRE_WORDS) begin
              n.tx_sh = (s.tx_c == PRE_WORDS - 6'h01) ? SFD_WORD : PRE_WORD;
              n.tx_b = WORD_BITS;
              n.tx_c = s.tx_c + 6'h01;
            end else begin
              n.tx_st = TX_DATA;
            end
          end else if (s.tx_last) begin
            if (tick) begin
              n.tx_en = 1'b0;
              n.tx_st = TX_IDLE;
              n.free_valid = 1'b1;
              n.free_buf = s.tx_buf;
              if (s.tx_buf[18:3] == PORT_ID) n.pmap[s.tx_buf[2:0]] = 1'b0;
            end
          end else if (!s.wrdy) begin
            n.wrdy = 1'b1;
          end
        end
        // sixteen bits per fetch; a missing word ends the frame early
        if (s.wrdy) begin
          n.wrdy = 1'b0;
          n.tx_sh = tx_word;
          n.tx_b = tx_word_valid ? WORD_BITS : 5'h00;
          n.tx_last = tx_word_valid ? tx_word_last : 1'b1;
        end
      end
    endcase
    n.deq_ready = (n.tx_st == TX_IDLE);
    ////////////////////////////////////////////////////////////////////////////
    // lowest free private buffer first
    for (int i = 7; i >= 0; i--) begin
      if (!n.pmap[i]) pick = 3'(i);
    end
    if (s.ctrl[CB_EN] && !n.cur_ok && !srst) begin
      if (!(&n.pmap)) begin
        n.pmap[pick] = 1'b1;
        n.cur = {PORT_ID, pick};
        n.cur_ok = 1'b1;
      end else if (pub_buf_valid) begin
        n.cur = pub_buf;
        n.cur_ok = 1'b1;
        n.pub_take = 1'b1;
      end
    end
    if (srst) begin
      n.pmap = 8'h00;
      n.cur_ok = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.hreadyout <= 1'b1;
      s.ctrl <= CTRL_RST;
    end else if (clk_en) begin
      s <= n;
    end
  end

  assign hreadyout = s.hreadyout;
  assign hrdata = s.hrdata;
  assign hresp = s.hresp;
  assign tx_en = s.tx_en;
  assign txd = s.txd;
  assign fwd_da = s.fwd;
  assign learn_sa = s.learn;
  assign qw_valid = s.qw_valid;
  assign qw_data = s.qw_data;
  assign enq_valid = s.enq_valid;
  assign enq_buf = s.enq_buf;
  assign rx_abort = s.abort;
  assign pub_take = s.pub_take;
  assign deq_ready = s.deq_ready;
  assign tx_word_ready = s.wrdy;
  assign free_valid = s.free_valid;
  assign free_buf = s.free_buf;
  assign phy_cmd = s.phy_cmd;
  assign phy_req = s.phy_req;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn || !clk_en);

  sequence s_phy_write;
    s.a_wr && s.a_addr == OFS_PHY && !s.phy_req;
  endsequence
  sequence s_srst_write;
    s.a_wr && s.a_addr == OFS_CTRL && hwdata[CB_SRST];
  endsequence

  chk_strap_ports: assert property (s.st_done |-> s.strap.ports == (s.strap.rmii ? PORTS_RMII : PORTS_MII)) else $error("port count wrong for PHY mode");
  chk_strap_stable: assert property (s.st_done |=> $stable(s.strap)) else $error("straps changed after capture");
  chk_sf_enqueue: assert property (enq_valid && !s.ctrl[CB_CUT] |-> $past(s.rx_st) == RX_DONE && $past(s.good)) else $error("store-and-forward enqueue without good frame");
  chk_learn_good: assert property (learn_sa.valid |-> $past(s.rx_st) == RX_DONE && $past(s.good) && !rx_abort) else $error("learning without good FCS");
  chk_tx_preamble: assert property ($rose(tx_en) |-> txd[1:0] == 2'b01 && s.tx_st == TX_PRE) else $error("frame does not open with preamble");
  chk_free_after: assert property (free_valid |-> !tx_en && $past(tx_en) && $past(s.tx_last)) else $error("buffer returned before transmit end");
  chk_mask_clear: assert property (s_srst_write |=> s.pmap == 8'h00 && !s.cur_ok) else $error("soft reset left mask set");
  chk_phy_issue: assert property (s_phy_write |=> phy_req ##0 phy_cmd.wdata == $past(hwdata[31:16])) else $error("PHY write not issued");
  chk_phy_hold: assert property (phy_req && !phy_ack |=> phy_req && $stable(phy_cmd)) else $error("PHY request dropped early");
  chk_pub_last: assert property (pub_take |-> &s.pmap) else $error("public buffer taken with private free");
  chk_abort_err: assert property (s.rx_st == RX_DATA && !s.er_seen && s.l2[5] |=> rx_abort) else $error("receive error not aborted");
endmodule : spf_port
`default_nettype wire

// ==== shared/spf_pkg.sv ====
// spf_pkg: constants and carrier types for one port slice of the packet flow engine
// assumes an AHB-Lite register bus and an MII/RMII PHY on a slow sampled link clock
package spf_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_BUF = 8'h08;
  localparam logic [7:0] OFS_RXGOOD = 8'h0c;
  localparam logic [7:0] OFS_PHY = 8'h10;
  localparam int CB_EN = 0;
  localparam int CB_CUT = 1;
  localparam int CB_SRST = 2;
  localparam int CB_AUTO = 3;
  localparam int CB_S100 = 4;
  localparam int CB_FDX = 5;
  localparam logic [5:0] CTRL_RST = 6'h08;
  localparam logic [2:0] HC_8 = 3'b111;
  localparam logic [2:0] HC_16 = 3'b110;
  localparam logic [2:0] HC_25 = 3'b101;
  localparam logic [2:0] HC_4 = 3'b100;
  localparam logic [2:0] HC_33 = 3'b011;
  localparam logic [1:0] SR_64K = 2'b11;
  localparam logic [1:0] SR_128K = 2'b10;
  localparam logic [1:0] SR_32K = 2'b01;
  localparam logic [4:0] PORTS_MII = 5'h0c;
  localparam logic [4:0] PORTS_RMII = 5'h10;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam int BUF_BYTES = 1536;
  localparam int NODE_BYTES = 12;
  localparam logic [7:0] BUF_QWORDS = 8'(BUF_BYTES / 8);
  localparam logic [7:0] CT_THRESH_QW = 8'h08;
  localparam logic [7:0] SPD_THR = 8'h10;
  localparam int IFG_BITS = 96;
  localparam logic [5:0] IFG_T_MII = 6'(IFG_BITS / 4);
  localparam logic [5:0] IFG_T_RMII = 6'(IFG_BITS / 2);
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [15:0] PRE_WORD = 16'h5555;
  localparam logic [15:0] SFD_WORD = 16'hd555;
  localparam logic [5:0] PRE_WORDS = 6'h04;
  localparam logic [2:0] DA_WORDS = 3'h3;
  localparam logic [2:0] HDR_WORDS = 3'h6;
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_RES = 32'hdebb20e3;

  typedef struct packed {
    logic [1:0] sram;
    logic phy;
    logic [2:0] hclk;
  } spf_strap_pins_t;
  typedef struct packed {
    logic [7:0] host_mhz;
    logic rmii;
    logic [7:0] sram_kw;
    logic [4:0] ports;
  } spf_strap_t;
  typedef struct packed {
    logic wr;
    logic [4:0] phy;
    logic [4:0] regno;
    logic [15:0] wdata;
  } spf_phy_cmd_t;
  typedef struct packed {
    logic [15:0] data;
    logic wr;
    logic [4:0] phy;
    logic [4:0] regno;
    logic busy;
    logic [3:0] rsv;
  } spf_phy_reg_t;
  typedef struct packed {
    logic valid;
    logic [47:0] mac;
  } spf_mac_t;
endpackage : spf_pkg

// ==== sim/spf_phy_model.sv ====
// spf_phy_model: behavioural mii phy on the far side of one port
// assumes the port samples rx on falling link clock and moves tx just after it
`timescale 1ns/1ps
`default_nettype none
module spf_phy_model (
  output logic rx_clk,
  output logic rx_dv,
  output logic [3:0] rxd,
  output logic rx_er,
  output logic crs,
  input wire logic tx_en,
  input wire logic [3:0] txd
);
  logic [3:0] txq [$];
  // receive clock runs free, 800 ns period
  initial begin
    rx_dv = 1'b0;
    rxd = 4'h0;
    rx_er = 1'b0;
    crs = 1'b0;
    rx_clk = 1'b0;
    forever #400 rx_clk = ~rx_clk;
  end
  // sampled on the next falling link clock, less than one link period after the port moves tx
  always @(negedge rx_clk) begin
    if (tx_en) txq.push_back(txd);
  end
  task automatic send(input logic [7:0] b [$], input int err_at);
    logic [3:0] n [$];
    for (int i = 0; i < 15; i++) n.push_back(4'h5);
    n.push_back(4'hd);
    foreach (b[i]) begin
      n.push_back(b[i][3:0]);
      n.push_back(b[i][7:4]);
    end
    foreach (n[i]) begin
      @(posedge rx_clk);
      rx_dv <= 1'b1;
      crs <= 1'b1;
      rxd <= n[i];
      rx_er <= (err_at >= 0 && i / 2 == err_at + 8);
    end
    @(posedge rx_clk);
    rx_dv <= 1'b0;
    crs <= 1'b0;
    rx_er <= 1'b0;
    // released data lines show the inverse, never a stale value
    rxd <= ~rxd;
  endtask : send
endmodule : spf_phy_model
`default_nettype wire

// ==== sim/test_switch_packet_flow_control.sv ====
// test_switch_packet_flow_control: directed bench for one port slice
// assumes one ahb-lite master, the phy model, and the bench as pool and phy manager
`timescale 1ns/1ps
`default_nettype none
module test_switch_packet_flow_control;
  import spf_pkg::*;
  localparam logic [47:0] DA = 48'h0a0b0c0d0e02;
  localparam logic [47:0] SA = 48'h161514131211;
  logic hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic rx_clk, rx_dv, rx_er, crs, tx_en, qw_valid, enq_valid, rx_abort, pub_take;
  logic deq_ready, tx_word_ready, free_valid, phy_req, phy_ack = 1'b0, clk_en = 1'b1;
  logic pub_buf_valid = 1'b0, deq_valid = 1'b0, tx_word_valid = 1'b0, tx_word_last = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [3:0] rxd, txd;
  logic [5:0] straps = 6'h3f;
  logic [15:0] tx_word = 16'h0, phy_rdata = 16'h5a5a;
  logic [18:0] enq_buf, free_buf, pub_buf = 19'h00200, deq_buf = 19'h0, enq_seen, free_seen;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [47:0] da_seen, sa_seen;
  logic [63:0] qw_data;
  spf_mac_t fwd_da, learn_sa;
  spf_phy_cmd_t phy_cmd;
  int failures = 0, checks = 0, n_qw = 0, n_enq = 0, n_ab = 0, n_lrn = 0, n_free = 0, n_mid = 0;
  spf_port DUT (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .strap_led_pins(straps),
    .rx_clk(rx_clk), .rx_dv(rx_dv), .rxd(rxd), .rx_er(rx_er), .crs(crs), .tx_en(tx_en),
    .txd(txd), .fwd_da(fwd_da), .learn_sa(learn_sa), .qw_valid(qw_valid), .qw_data(qw_data),
    .enq_valid(enq_valid), .enq_buf(enq_buf), .rx_abort(rx_abort), .pub_take(pub_take),
    .pub_buf_valid(pub_buf_valid), .pub_buf(pub_buf), .deq_valid(deq_valid),
    .deq_buf(deq_buf), .deq_ready(deq_ready), .tx_word_valid(tx_word_valid),
    .tx_word(tx_word), .tx_word_last(tx_word_last), .tx_word_ready(tx_word_ready),
    .free_valid(free_valid), .free_buf(free_buf), .phy_cmd(phy_cmd), .phy_req(phy_req),
    .phy_ack(phy_ack), .phy_rdata(phy_rdata));
  spf_phy_model phy (.rx_clk(rx_clk), .rx_dv(rx_dv), .rxd(rxd), .rx_er(rx_er), .crs(crs),
    .tx_en(tx_en), .txd(txd));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // pulse monitor, public pool source and phy management responder
  always @(posedge hclk) begin
    if (qw_valid === 1'b1) n_qw++;
    if (rx_abort === 1'b1) n_ab++;
    if (fwd_da.valid === 1'b1) da_seen = fwd_da.mac;
    if (enq_valid === 1'b1) begin
      n_enq++;
      enq_seen = enq_buf;
      if (rx_dv) n_mid++;
    end
    if (learn_sa.valid === 1'b1) begin
      n_lrn++;
      sa_seen = learn_sa.mac;
    end
    if (free_valid === 1'b1) begin
      n_free++;
      free_seen = free_buf;
    end
    // free list head is set before traffic, then advances per take
    if (pub_take === 1'b1) pub_buf <= pub_buf + 19'h1;
    phy_ack <= (phy_req === 1'b1 && phy_ack === 1'b0);
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [63:0] want, input logic [63:0] got);
    checks++;
    if (got !== want) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, want, got);
    end
  endtask : chk
  task automatic edge_until(input string what, input int lim, ref logic s);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (s !== 1'b1 && n < lim);
    if (s !== 1'b1) begin
      chk(what, 64'h1, 64'h0);
      end_sim();
    end
  endtask : edge_until
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    edge_until("ahb addr", 50, hreadyout);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    edge_until("ahb data", 50, hreadyout);
    rd = hrdata;
  endtask : ahb
  function automatic logic [31:0] crc32(input logic [7:0] b [$]);
    logic [31:0] c;
    c = CRC_INIT;
    foreach (b[i]) begin
      c ^= 32'(b[i]);
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction : crc32
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_straps;
    logic [2:0] hc [5] = '{HC_8, HC_16, HC_25, HC_4, HC_33};
    logic [7:0] mhz [5] = '{8'h08, 8'h10, 8'h19, 8'h04, 8'h21};
    logic [1:0] sr [3] = '{SR_64K, SR_128K, SR_32K};
    logic [7:0] kw [3] = '{8'h40, 8'h80, 8'h20};
    for (int i = 0; i < 5; i++) begin
      hresetn <= 1'b0;
      straps <= {sr[i % 3], 1'(i % 2), hc[i]};
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (8) @(posedge hclk);
      ahb(1'b0, 32'(OFS_STATUS), 32'h0);
      chk("status", 64'({mhz[i], 1'(i % 2), kw[i % 3], (i % 2) ? PORTS_RMII : PORTS_MII}),
        64'(rd[21:0]));
    end
  endtask : t_straps
  // mode 0 good, 1 receive error, 2 bad fcs, 3 good in cut-through
  task automatic t_rx(input int mode, input int pay);
    logic [7:0] b [$];
    logic [31:0] c;
    int q0, e0, a0, l0, m0;
    for (int i = 0; i < 6; i++) b.push_back(DA[8*i +: 8]);
    for (int i = 0; i < 6; i++) b.push_back(SA[8*i +: 8]);
    for (int i = 0; i < pay; i++) b.push_back(8'(i));
    c = crc32(b) ^ ((mode == 2) ? 32'h1 : 32'h0);
    for (int i = 0; i < 4; i++) b.push_back(c[8*i +: 8]);
    q0 = n_qw;
    e0 = n_enq;
    a0 = n_ab;
    l0 = n_lrn;
    m0 = n_mid;
    phy.send(b, (mode == 1) ? 14 : -1);
    repeat (20) @(posedge hclk);
    chk("da", 64'(DA), 64'(da_seen));
    if (mode == 0) chk("quad words", 64'((b.size() + 7) / 8), 64'(n_qw - q0));
    chk("abort", 64'(mode == 1 || mode == 2), 64'(n_ab - a0));
    chk("learn", 64'(mode % 3 == 0), 64'(n_lrn - l0));
    chk("enqueue", 64'(mode % 3 == 0), 64'(n_enq - e0));
    chk("early enqueue", 64'(mode == 3), 64'(n_mid - m0));
    if (mode % 3 == 0) chk("sa", 64'(SA), 64'(sa_seen));
  endtask : t_rx
  task automatic t_tx;
    logic [15:0] w [4] = '{16'h1234, 16'h5678, 16'h9abc, 16'hdef0};
    logic [3:0] want [$];
    phy.txq.delete();
    edge_until("deq ready", 100, deq_ready);
    deq_valid <= 1'b1;
    deq_buf <= 19'h00123;
    @(posedge hclk);
    deq_valid <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      tx_word_valid <= 1'b1;
      tx_word <= w[i];
      tx_word_last <= (i == 3);
      edge_until("tx word", 2000, tx_word_ready);
    end
    tx_word_valid <= 1'b0;
    tx_word_last <= 1'b0;
    edge_until("free", 500, free_valid);
    @(posedge hclk);
    for (int i = 0; i < 15; i++) want.push_back(4'h5);
    want.push_back(4'hd);
    foreach (w[i]) for (int k = 0; k < 4; k++) want.push_back(w[i][4*k +: 4]);
    chk("tx nibbles", 64'(want.size()), 64'(phy.txq.size()));
    foreach (want[i]) if (i < phy.txq.size()) chk("txd", 64'(want[i]), 64'(phy.txq[i]));
    chk("freed", 64'h123, 64'(free_seen));
  endtask : t_tx
  task automatic t_phy(input logic [31:0] wd);
    ahb(1'b1, 32'(OFS_PHY), wd);
    edge_until("phy req", 20, phy_req);
    chk("phy cmd", 64'({wd[15], wd[14:10], wd[9:5], wd[31:16]}), 64'(phy_cmd));
    repeat (4) @(posedge hclk);
  endtask : t_phy
  // private pool runs dry first, then a public buffer is taken only once offered
  task automatic t_pool;
    repeat (6) t_rx(0, 4);
    ahb(1'b0, 32'(OFS_BUF), 32'h0);
    chk("private used up", 64'({1'b0, 19'h00007, 8'hff}), 64'(rd[27:0]));
    pub_buf_valid <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, 32'(OFS_BUF), 32'h0);
    chk("public buffer", 64'({1'b1, 19'h00200, 8'hff}), 64'(rd[27:0]));
  endtask : t_pool
  // a write made while the clock enable is low must not land
  task automatic t_freeze;
    clk_en <= 1'b0;
    ahb(1'b1, 32'(OFS_CTRL), 32'h00000021);
    clk_en <= 1'b1;
    ahb(1'b0, 32'(OFS_CTRL), 32'h0);
    chk("frozen ctrl", 64'h0, 64'(rd));
  endtask : t_freeze
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    t_straps();
    ahb(1'b0, 32'(OFS_CTRL), 32'h0);
    chk("ctrl reset", 64'(CTRL_RST), 64'(rd));
    ahb(1'b1, 32'(OFS_CTRL), 32'h0000003b);
    ahb(1'b0, 32'(OFS_CTRL), 32'h0);
    chk("ctrl", 64'h3b, 64'(rd));
    ahb(1'b1, 32'h00000040, 32'hffffffff);
    ahb(1'b0, 32'h00000040, 32'h0);
    chk("unmapped", 64'h0, 64'({hresp, rd}));
    ahb(1'b1, 32'(OFS_CTRL), 32'h00000001);
    ahb(1'b0, 32'(OFS_BUF), 32'h0);
    chk("held private", 64'({1'b1, 16'h0000}), 64'({rd[27], rd[26:11]}));
    chk("pmap", 64'h1, 64'($countones(rd[7:0])));
    t_rx(0, 4);
    chk("first buffer", 64'h0, 64'(enq_seen[18:3]));
    t_rx(1, 4);
    t_rx(2, 4);
    ahb(1'b1, 32'(OFS_CTRL), 32'h00000003);
    t_rx(3, 80);
    ahb(1'b0, 32'(OFS_RXGOOD), 32'h0);
    chk("good count", 64'h2, 64'(rd[15:0]));
    t_pool();
    t_tx();
    t_phy(32'hbeef8440);
    t_phy(32'h00000440);
    ahb(1'b0, 32'(OFS_PHY), 32'h0);
    chk("phy read", 64'({16'h5a5a, 1'b0}), 64'({rd[31:16], rd[4]}));
    ahb(1'b1, 32'(OFS_CTRL), 32'h00000004);
    ahb(1'b0, 32'(OFS_BUF), 32'h0);
    chk("pmap cleared", 64'h0, 64'({rd[27], rd[7:0]}));
    ahb(1'b0, 32'(OFS_CTRL), 32'h0);
    chk("srst clears", 64'h0, 64'(rd[2]));
    t_freeze();
    end_sim();
  end
endmodule : test_switch_packet_flow_control
`default_nettype wire
